//--- hw/tsq_sequencer.sv
// Purpose: Serial control and conversion sequencer of a touch digitizer
// Assumes: Host drives cs_n, din and the serial clock; sample_word is
//          the front end result, stable in the clk domain
// Notes:   Link logic runs on the serial clock and is cleared by cs_n
//
// Functional notes
// RQ1: Full conversion fits a 24-clock frame
// RQ2: Chip select low releases busy and data
// RQ3: First eight clocks load control bits
// RQ4: Enough bits start acquisition, switches on
// RQ5: Three acquisition clocks, then hold and convert
// RQ6: Busy high at hold, low next fall
// RQ7: Single-ended modes drop switches at hold
// RQ8: Twelve clocks convert and shift result out
// RQ9: Ratiometric mode keeps switches on converting
// RQ10: Thirteenth clock gives LSB, then zeros
// RQ11: Clocks continuous or in eight-clock bursts
// RQ12: Channel 001 Y drivers, 101 X drivers
// RQ13: Power modes 00/01/10 turn Y-minus on
// RQ14: Mode 11 keeps drivers until change/deselect
// RQ15: New start bit accepted during readout
// RQ16: Stay powered during pauses between bytes
// RQ17: Fifteen-clock cycle: 3 acquire, 12 convert
// RQ18: Resolution bit set selects 8-bit conversion
// RQ19: 8-bit conversion ends four clocks earlier
// RQ20: 8-bit host may use 8 or 12-clock transfers
// RQ21: First high bit starts control word
// RQ22: Start, channel, mode, reference, power fields
// RQ23: Mode 00 powers down after conversion
// RQ24: Result MSB first, changing on falls
// RQ25: Chip select high floats outputs, ignores clock
module tsq_sequencer
(
   // System clock and reset
   input  logic                clk,
   input  logic                reset,
   // Serial link from the host
   input  logic                serial_conv_clock,
   input  logic                cs_n,
   input  logic                din,
   output logic                sdout,
   output logic                sdout_oe,
   output logic                busy,
   output logic                busy_oe,
   // Converter front end
   input  logic [11:0]         sample_word,
   // Panel switch and power controls
   output logic                y_drv_on,
   output logic                x_drv_on,
   output logic                y_minus_on,
   output logic                adc_powered,
   output logic                ref_powered,
   // Applied configuration
   output logic [2:0]          channel_select,
   output logic                res_8bit,
   output logic                ref_mode_select,
   output logic [1:0]          power_mgmt_field,
   output tsq_pkg::tsq_phase_type phase
);
   import tsq_pkg::*;

   // Link domain, rising edges
   logic [4:0]  cnt_q;
   logic [4:0]  cnt_d;
   logic        act_q;
   logic        act_d;
   logic [7:0]  cw_q;
   logic [7:0]  cw_d;
   logic        acq_q;
   logic        acq_d;
   logic        ack_s1_q;
   logic        ack_s2_q;

   // Link domain, falling edges
   logic        busy_q;
   logic        sdo_q;
   logic        sdo_d;
   logic [11:0] osh_q;
   logic [11:0] osh_d;
   logic [3:0]  left_q;
   logic [3:0]  left_d;
   logic        conv_q;
   logic        conv_d;

   // System domain
   logic        cs_s1_q;
   logic        cs_s2_q;
   logic        cs_s3_q;
   logic        acq_s1_q;
   logic        acq_s2_q;
   logic        acq_s3_q;
   logic        conv_s1_q;
   logic        conv_s2_q;
   logic        conv_s3_q;
   logic        ack_q;
   logic [11:0] held_q;
   logic [2:0]  chan_q;
   logic        mode_q;
   logic        ser_q;
   logic [1:0]  pm_q;
   logic        ydrv_q;
   logic        ydrv_d;
   logic        xdrv_q;
   logic        xdrv_d;
   logic        yminus_q;
   logic        yminus_d;
   logic        adc_q;
   logic        adc_d;
   logic        ref_q;
   logic        oe_q;
   tsq_phase_type phase_q;
   tsq_phase_type phase_d;

   // Control word decode in the link domain
   wire         mode8_w  = cw_q[CW_MODE];                      // RQ18
   wire [4:0]   limit_w  = mode8_w ? RESTART_8 : RESTART_12;   // RQ20
   wire         open_w   = !act_q || (cnt_q >= limit_w);       // RQ15 RQ17
   wire         start_w  = din && open_w;                      // RQ21
   wire         hold_w   = act_q && (cnt_q == HOLD_CNT);       // RQ5
   wire [2:0]   chan_new = cw_q[CW_CHAN_HI:CW_CHAN_LO];        // RQ22
   wire         ser_new  = cw_q[CW_REF];                       // RQ22
   wire [1:0]   pm_new   = cw_q[CW_PM_HI:CW_PM_LO];            // RQ22

   // Frame counter only counts edges, so bursts and gaps are alike
   assign act_d = act_q || start_w;
   assign cnt_d = start_w ? CNT_ONE :
                  (act_q && cnt_q != CNT_MAX) ? cnt_q + CNT_ONE :
                  cnt_q;                                       // RQ1 RQ11
   assign acq_d = act_d && (cnt_d >= ACQ_FIRST) &&
                  (cnt_d <= HOLD_CNT);                         // RQ4 RQ5

   assign cw_d[CW_START] = start_w ? 1'b1 : cw_q[CW_START];
   genvar i;
   generate
      for (i = 0; i < CW_START; i++)
      begin : g_cw
         // Each bit lands in place as it arrives
         assign cw_d[i] = start_w ? 1'b0 :
                          (act_q && cnt_q == 5'(CW_START - i)) ? din :
                          cw_q[i];                             // RQ3
      end
   endgenerate

   always_ff @(posedge serial_conv_clock or posedge cs_n)
   begin
      if (cs_n)
      begin
         cnt_q    <= CNT_ZERO;                                 // RQ25
         act_q    <= 1'b0;
         cw_q     <= CW_RESET;
         acq_q    <= 1'b0;
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
      end
      else
      begin
         cnt_q    <= cnt_d;
         act_q    <= act_d;
         cw_q     <= cw_d;
         acq_q    <= acq_d;
         ack_s1_q <= ack_q;
         ack_s2_q <= ack_s1_q;
      end
   end

   // Word taken only once the handshake came back; else zeros
   wire [11:0]  word_w   = mode8_w ? {held_q[11:4], 4'h0} : held_q;
   wire [11:0]  load_w   = ack_s2_q ? word_w : WORD_ZERO;
   wire [3:0]   bits_w   = mode8_w ? RES_BITS_8 : RES_BITS_12; // RQ19

   assign osh_d  = hold_w ? load_w : {osh_q[10:0], 1'b0};      // RQ10 RQ24
   assign sdo_d  = hold_w ? 1'b0 : osh_q[11];                  // RQ8 RQ24
   assign left_d = hold_w ? bits_w :
                   (left_q != LEFT_ZERO) ? left_q - LEFT_ONE :
                   LEFT_ZERO;                                  // RQ8
   assign conv_d = (left_d != LEFT_ZERO);

   // Outputs change on falls so the host samples on rises
   always_ff @(negedge serial_conv_clock or posedge cs_n)
   begin
      if (cs_n)
      begin
         busy_q <= 1'b0;                                       // RQ25
         sdo_q  <= 1'b0;
         osh_q  <= WORD_ZERO;
         left_q <= LEFT_ZERO;
         conv_q <= 1'b0;
      end
      else
      begin
         busy_q <= hold_w;                                     // RQ6
         sdo_q  <= sdo_d;
         osh_q  <= osh_d;
         left_q <= left_d;
         conv_q <= conv_d;
      end
   end

   // System domain: level synchronisers and edge detects
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cs_s1_q   <= 1'b1;
         cs_s2_q   <= 1'b1;
         cs_s3_q   <= 1'b1;
         acq_s1_q  <= 1'b0;
         acq_s2_q  <= 1'b0;
         acq_s3_q  <= 1'b0;
         conv_s1_q <= 1'b0;
         conv_s2_q <= 1'b0;
         conv_s3_q <= 1'b0;
      end
      else
      begin
         cs_s1_q   <= cs_n;
         cs_s2_q   <= cs_s1_q;
         cs_s3_q   <= cs_s2_q;
         acq_s1_q  <= acq_q;
         acq_s2_q  <= acq_s1_q;
         acq_s3_q  <= acq_s2_q;
         conv_s1_q <= conv_q;
         conv_s2_q <= conv_s1_q;
         conv_s3_q <= conv_s2_q;
      end
   end

   wire cs_rise   = cs_s2_q && !cs_s3_q;
   wire acq_rise  = acq_s2_q && !acq_s3_q;
   wire conv_rise = conv_s2_q && !conv_s3_q;
   wire conv_fall = !conv_s2_q && conv_s3_q;
   wire end_conv  = conv_fall && (phase_q == TSQ_CONV); // Overlapped word may already acquire
   wire keep_on   = (pm_q == PM_ALWAYS_ON);
   wire keep_new  = (pm_new == PM_ALWAYS_ON);
   wire changed   = (ser_new != ser_q) || (pm_new != pm_q);

   // Single-ended drops at hold unless held on by an unchanged mode 11
   wire drop_hold = ser_new && (!keep_new || changed);         // RQ7 RQ9 RQ14

   assign ydrv_d = cs_rise   ? 1'b0 :                          // RQ14
                   acq_rise  ? (chan_new == CHAN_Y_DRV) :      // RQ4 RQ12
                   conv_rise ? (ydrv_q && !drop_hold) :
                   end_conv  ? (ydrv_q && keep_on) :           // RQ14
                   ydrv_q;
   assign xdrv_d = cs_rise   ? 1'b0 :                          // RQ14
                   acq_rise  ? (chan_new == CHAN_X_DRV) :      // RQ4 RQ12
                   conv_rise ? (xdrv_q && !drop_hold) :
                   end_conv  ? (xdrv_q && keep_on) :           // RQ14
                   xdrv_q;
   assign yminus_d = (cs_rise || (end_conv && !acq_rise)) ? !keep_on : // RQ13
                     acq_rise ? 1'b0 :
                     yminus_q;
   // No idle timer: power holds however long the clock pauses
   assign adc_d = (acq_rise || conv_rise) ? 1'b1 :             // RQ16
                  ((cs_rise || end_conv) && !pm_q[CW_PM_LO]) ? 1'b0 :
                  adc_q;                                       // RQ23

   always_comb
   begin
      phase_d = phase_q;
      if (cs_rise || (end_conv && !acq_rise))
         phase_d = TSQ_IDLE;
      else if (conv_rise)
         phase_d = TSQ_CONV;
      else if (acq_rise)
         phase_d = TSQ_ACQ;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         phase_q  <= TSQ_IDLE;
         ydrv_q   <= 1'b0;
         xdrv_q   <= 1'b0;
         yminus_q <= 1'b1;
         adc_q    <= 1'b0;
         oe_q     <= 1'b0;
      end
      else
      begin
         phase_q  <= phase_d;
         ydrv_q   <= ydrv_d;
         xdrv_q   <= xdrv_d;
         yminus_q <= yminus_d;
         adc_q    <= adc_d;
         oe_q     <= !cs_s2_q;                                 // RQ2 RQ25
      end
   end

   // Captures are safe: link fields sit still for several clocks here
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ack_q  <= 1'b0;
         held_q <= WORD_ZERO;
         chan_q <= CHAN_RESET;
         mode_q <= 1'b0;
         ser_q  <= 1'b0;
         pm_q   <= PM_RESET;
         ref_q  <= 1'b0;
      end
      else
      begin
         ack_q  <= acq_s2_q;
         if (acq_rise)
         begin
            held_q <= sample_word;                             // RQ4
            chan_q <= chan_new;
            mode_q <= mode8_w;                                 // RQ18
         end
         if (conv_rise)
         begin
            ser_q <= ser_new;                                  // RQ5
            pm_q  <= pm_new;
            ref_q <= pm_new[CW_PM_HI];
         end
      end
   end

   assign sdout            = sdo_q;
   assign busy             = busy_q;
   assign sdout_oe         = oe_q;
   assign busy_oe          = oe_q;
   assign y_drv_on         = ydrv_q;
   assign x_drv_on         = xdrv_q;
   assign y_minus_on       = yminus_q;
   assign adc_powered      = adc_q;
   assign ref_powered      = ref_q;
   assign channel_select   = chan_q;
   assign res_8bit         = mode_q;
   assign ref_mode_select  = ser_q;
   assign power_mgmt_field = pm_q;
   assign phase            = phase_q;

endmodule // tsq_sequencer

//--- shared/tsq_pkg.sv
// Purpose: Constants and types for the touch ADC serial sequencer
// Assumes: Control word arrives MSB first on the serial data input
// Notes:   Shared by the design and the bench
package tsq_pkg;

   // Control word field positions
   localparam int CW_START   = 7;
   localparam int CW_CHAN_HI = 6;
   localparam int CW_CHAN_LO = 4;
   localparam int CW_MODE    = 3;
   localparam int CW_REF     = 2;
   localparam int CW_PM_HI   = 1;
   localparam int CW_PM_LO   = 0;

   // Frame timing in serial clocks
   localparam int       FRAME_CLOCKS = 24;
   localparam logic [4:0] CNT_ZERO   = 5'h00;
   localparam logic [4:0] CNT_ONE    = 5'h01;
   localparam logic [4:0] CNT_MAX    = 5'h1f;
   localparam logic [4:0] ACQ_FIRST  = 5'h05;
   localparam logic [4:0] HOLD_CNT   = 5'h08;
   localparam logic [4:0] RESTART_12 = 5'h0f;
   localparam logic [4:0] RESTART_8  = 5'h0b;
   localparam logic [3:0] RES_BITS_12 = 4'hc;
   localparam logic [3:0] RES_BITS_8  = 4'h8;
   localparam logic [3:0] LEFT_ZERO   = 4'h0;
   localparam logic [3:0] LEFT_ONE    = 4'h1;

   // Field codes
   localparam logic [2:0] CHAN_Y_DRV   = 3'h1;
   localparam logic [2:0] CHAN_X_DRV   = 3'h5;
   localparam logic [1:0] PM_ALWAYS_ON = 2'h3;

   // Reset values
   localparam logic [7:0]  CW_RESET   = 8'h00;
   localparam logic [7:0]  CW_STARTED = 8'h80;
   localparam logic [11:0] WORD_ZERO  = 12'h000;
   localparam logic [2:0]  CHAN_RESET = 3'h0;
   localparam logic [1:0]  PM_RESET   = 2'h0;

   typedef enum logic [1:0]
   {
      TSQ_IDLE = 2'b00,
      TSQ_ACQ  = 2'b01,
      TSQ_CONV = 2'b10
   } tsq_phase_type;

endpackage

//--- tb/tsq_host_model.sv
// Purpose: Host serial port model driving the sequencer link
// Assumes: Link clock of 125 ns that stands low between bursts
// Notes:   A released data line shows the inverse of its last level
module tsq_host_model
(
   // Link to the device
   output logic serial_conv_clock,
   output logic cs_n,
   output logic din,
   input  logic sdout,
   input  logic sdout_oe,
   input  logic busy
);
   timeunit 1ns;
   timeprecision 100ps;
   logic line_q;
   wire  line = sdout_oe ? sdout : ~line_q;
   // Sure rising chip select clears the link flops before reset ends
   initial
   begin
      serial_conv_clock = 1'b0;
      cs_n = 1'b0;
      din = 1'b0;
      line_q = 1'b0;
      #1 cs_n = 1'b1;
   end
   // Wait lets the synchronised enable come up first
   task automatic select();
      cs_n = 1'b0;
      #100;
   endtask
   task automatic deselect();
      #100;
      cs_n = 1'b1;
      #100;
   endtask
   // MSB first; run_word splits frames into bursts with pauses
   task automatic clocks(input int n, input logic [47:0] pattern, output logic [47:0] rx,
                         output logic [47:0] bz);
      rx = '0;
      bz = '0;
      for (int i = n - 1; i >= 0; i--)
      begin
         din = pattern[i];
         #62.5 serial_conv_clock = 1'b1;
         rx[i] = line;
         bz[i] = busy;
         line_q = line;
         #62.5 serial_conv_clock = 1'b0;
      end
   endtask
endmodule // tsq_host_model

//--- tb/tsq_sequencer_sva.sv
// Purpose: Port-level checks of the touch ADC serial sequencer
// Assumes: Link checks only hold while chip select is low
// Notes:   Bound to the design from the bench top
module tsq_sequencer_sva import tsq_pkg::*;
(
   // Clocks and resets
   input logic                   clk,
   input logic                   reset,
   input logic                   serial_conv_clock,
   // Link
   input logic                   cs_n,
   input logic                   busy,
   input logic                   sdout_oe,
   input logic                   busy_oe,
   // Controls and configuration
   input logic                   y_drv_on,
   input logic                   x_drv_on,
   input logic                   y_minus_on,
   input logic                   adc_powered,
   input logic                   ref_powered,
   input logic [2:0]             channel_select,
   input logic [1:0]             power_mgmt_field,
   input logic                   res_8bit,
   input tsq_pkg::tsq_phase_type phase
);
   timeunit 1ns;
   timeprecision 100ps;
   a_oe_follow: assert property (@(posedge clk) disable iff (reset)
      !cs_n [*4] |-> sdout_oe && busy_oe) else $error("outputs not enabled");
   a_oe_float: assert property (@(posedge clk) disable iff (reset)
      cs_n [*4] |-> !sdout_oe && !busy_oe) else $error("outputs not floated");
   a_busy_pulse: assert property (@(negedge serial_conv_clock) disable iff (cs_n)
      $rose(busy) |=> !busy [*8]) else $error("busy pulse too long");
   a_drv_unique: assert property (@(posedge clk) disable iff (reset)
      y_drv_on || x_drv_on |-> !(y_drv_on && x_drv_on)
         && channel_select == (y_drv_on ? CHAN_Y_DRV : CHAN_X_DRV))
      else $error("driver does not match channel");
   a_conv_entry: assert property (@(posedge clk) disable iff (reset)
      $changed(phase) && phase == TSQ_CONV |-> $past(phase) == TSQ_ACQ)
      else $error("conversion not after acquisition");
   a_adc_conv: assert property (@(posedge clk) disable iff (reset)
      phase == TSQ_CONV [*2] |-> adc_powered) else $error("converter off in conversion");
   a_ref_pm: assert property (@(posedge clk) disable iff (reset)
      phase == TSQ_CONV [*2] |-> ref_powered == power_mgmt_field[1])
      else $error("reference power wrong");
   a_ymin_end: assert property (@(posedge clk) disable iff (reset)
      $past(phase) == TSQ_CONV && phase == TSQ_IDLE && sdout_oe
         && power_mgmt_field != PM_ALWAYS_ON |-> ##[0:2] y_minus_on)
      else $error("y minus not on after conversion");
   a_pm11_keep: assert property (@(posedge clk) disable iff (reset)
      $past(phase) == TSQ_CONV && phase == TSQ_IDLE && sdout_oe
         && power_mgmt_field == PM_ALWAYS_ON |-> $stable({y_drv_on, x_drv_on}))
      else $error("drivers dropped in always-on mode");
   c_busy: cover property (@(negedge serial_conv_clock) $rose(busy));
   c_x_drv: cover property (@(posedge clk) x_drv_on);
   c_conv8: cover property (@(posedge clk) phase == TSQ_CONV && res_8bit);
endmodule // tsq_sequencer_sva

//--- tb/tsq_sequencer_tb_top.sv
// Purpose: Self-checking bench for the touch ADC serial sequencer
// Assumes: Host model owns the link pins; bench drives clk-side inputs
// Notes:   Control words cover every power mode and both driver channels
module tsq_sequencer_tb_top import tsq_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, reset, serial_conv_clock, cs_n, din, sdout, sdout_oe, busy, busy_oe;
   logic y_drv_on, x_drv_on, y_minus_on, adc_powered, ref_powered, res_8bit, ref_mode_select;
   logic [11:0]   sample_word;
   logic [2:0]    channel_select;
   logic [1:0]    power_mgmt_field;
   tsq_phase_type phase;
   logic [47:0]   r0, r1, r2, b0, b1, b2;
   int            bad_count = 0;
   int            samples_checked = 0;
   logic [7:0]    cw_tab [4] = '{8'h93, 8'hd8, 8'h95, 8'h86};
   logic [11:0]   smp_tab [4] = '{12'ha5c, 12'h3c7, 12'hf01, 12'h7e2};

   tsq_sequencer dut (.clk, .reset, .serial_conv_clock, .cs_n, .din, .sdout, .sdout_oe,
      .busy, .busy_oe, .sample_word, .y_drv_on, .x_drv_on, .y_minus_on, .adc_powered,
      .ref_powered, .channel_select, .res_8bit, .ref_mode_select, .power_mgmt_field, .phase);
   tsq_host_model host (.serial_conv_clock, .cs_n, .din, .sdout, .sdout_oe, .busy);

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check(input logic [47:0] seen, input logic [47:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask

   task automatic conclude();
      if (bad_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Three bursts of eight with checks in the pauses
   task automatic run_word(input logic [7:0] cw, input logic [11:0] smp);
      logic [2:0] ch;
      logic [1:0] pm;
      logic       conv, on, keep;
      logic [4:0] fin;
      ch = cw[CW_CHAN_HI:CW_CHAN_LO];
      pm = cw[CW_PM_HI:CW_PM_LO];
      conv = !cw[CW_MODE];
      keep = pm == PM_ALWAYS_ON;
      on = conv ? (!cw[CW_REF] || keep) : keep;
      fin = {keep && ch == CHAN_Y_DRV, keep && ch == CHAN_X_DRV, !keep, pm[0], pm[1]};
      @(negedge clk);
      sample_word = smp;
      host.select();
      check(sdout_oe & busy_oe, 48'h1);
      host.clocks(8, {40'h0, cw}, r0, b0);
      #300;
      host.clocks(8, 48'h0, r1, b1);
      #300;
      check(phase, conv ? TSQ_CONV : TSQ_IDLE);
      check(adc_powered, conv | pm[0]);
      check({y_drv_on, x_drv_on}, {on && ch == CHAN_Y_DRV, on && ch == CHAN_X_DRV});
      host.clocks(8, 48'h0, r2, b2);
      #300;
      check({r1[6:0], r2[7:0]}, conv ? {smp, 3'h0} : {smp[11:4], 7'h00});
      check({b0[7:0], b1[7:0], b2[7:0]}, 24'h008000);
      check({channel_select, res_8bit, ref_mode_select, power_mgmt_field}, cw[6:0]);
      check({y_drv_on, x_drv_on, y_minus_on, adc_powered, ref_powered}, fin);
      host.deselect();
      check({sdout_oe, busy_oe, y_drv_on, x_drv_on}, 48'h0);
   endtask

   initial
   begin
      reset = 1'b1;
      sample_word = 12'h000;
      repeat (20) @(negedge clk);
      reset = 1'b0;
      repeat (2) @(negedge clk);
      foreach (cw_tab[i]) run_word(cw_tab[i], smp_tab[i]);
      @(negedge clk);
      sample_word = 12'h5a3;
      host.select();
      // A stray high bit inside the first readout must be ignored
      host.clocks(48, {8'hb5, 7'h08, 8'hd8, 3'h0, 8'h93, 14'h0}, r0, b0);
      #300;
      check({r0[38:27], r0[23:13], r0[12:1]}, {12'h5a3, 8'h5a, 3'h0, 12'h5a3});
      check(b0, 48'h0080_0100_2000);
      check({channel_select, power_mgmt_field, y_drv_on}, {3'h1, 2'h3, 1'b1});
      host.deselect();
      host.clocks(24, {24'h0, 8'h93, 16'h0}, r1, b1);
      #300;
      check({phase, sdout_oe, y_drv_on}, 48'h0);
      conclude();
   end

   initial
   begin
      #100us;
      bad_count++;
      conclude();
   end
endmodule // tsq_sequencer_tb_top

bind tsq_sequencer tsq_sequencer_sva chk (.clk, .reset, .serial_conv_clock, .cs_n, .busy,
   .sdout_oe, .busy_oe, .y_drv_on, .x_drv_on, .y_minus_on, .adc_powered, .ref_powered,
   .channel_select, .power_mgmt_field, .res_8bit, .phase);
